// >>> ldc_dimming_core.sv
// Six-channel LED dimming controller: PWM, hybrid, phase shift, fail-safe and reference DAC.
//
// What this block does
// - 8-bit reference code, clamped to 240-255 (0.6-0.6375V).
// - Fail-safe pin with enable forces everything on.
// - Fail-safe release applies registers next cycle.
// - Latch sink current and address at power-up.
// - External select takes dim pin, sampled 20MHz.
// - Internal on-time is 18 bits of 50ns.
// - Nonzero on-time below minimum gives 500ns.
// - Over-period is 100%, zero is off.
// - Measure dim frequency once after enable.
// - Hybrid reduces current, then chops below crossover.
// - Hybrid source is dim duty or on-time.
// - Low-dim below 50us, leave above 51us.
// - Normal mode switches only while dimming high.
// - Low-dim suspends sink monitoring, not boost monitor.
// - Per-channel low-dim; any forces continuous boost.
// - Phase shift spreads strings by enabled count, internal only.
// - Zero on-time turns string off, internal non-hybrid only.
// - Reference counter steps on dim edges (external), period starts (internal), or 10ms.
// - Enable bit starts boost; toggle restarts.
`timescale 1ns/100ps
`include "ldc_cfg.svh"
`default_nettype none
module ldc_dimming_core import ldc_pkg::*; #(
  parameter int unsigned CH = 6,
  parameter int unsigned PWM_PERIOD_TICKS = `LDC_PWM_PERIOD_TICKS,
  parameter int unsigned REFRESH_CYCLES = `LDC_REFRESH_CYCLES
) (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic resetn_in,
  // Register port from the serial interface.
  input wire ldc_reg_req_s reg_req_in,
  output logic [7:0] reg_rdata_out,
  // Pins and analog status.
  input wire logic dim_pin_in,
  input wire logic failsafe_pin_in,
  input wire logic device_en_in,
  input wire logic [3:0] failsafe_code_in,
  input wire logic headroom_low_in,
  input wire logic headroom_high_in,
  // Sink and converter control.
  output logic [CH-1:0] sink_on_out,
  output logic [17:0] hybrid_level_out,
  output logic [7:0] dac_code_out,
  output logic boost_on_out,
  output logic boost_switch_out,
  output logic boost_restart_out,
  output logic low_dim_out,
  output logic short_detect_en_out,
  output logic sink_monitor_en_out,
  output logic boost_monitor_en_out,
  // Power-up straps.
  output logic [1:0] failsafe_current_out,
  output logic failsafe_avail_out,
  output logic [6:0] slave_addr_out
);
  localparam logic [17:0] PER = 18'(PWM_PERIOD_TICKS);
  localparam logic [17:0] MIN_ON = 18'(`LDC_MIN_ON_TICKS);
  localparam logic [17:0] MAX_PER = 18'(`LDC_MAX_PER_TICKS);
  localparam logic [7:0] DAC_MIN = 8'(`LDC_DAC_MIN);
  localparam logic [7:0] DAC_MAX = (`LDC_DAC_MAX_RAW > 255) ? 8'hFF : 8'(`LDC_DAC_MAX_RAW);
  localparam logic [2:0] TDIV = 3'(`LDC_TICK_DIV);
  localparam int MIN_CLKS = `LDC_MIN_ON_TICKS * `LDC_TICK_DIV;

  logic [6:0] sync1_q, sync2_q;
  logic [2:0] tdiv_q;
  logic tick, dim_s, fs_s, en_s, dim_prev_q, rise, fall;
  logic [7:0] ctrl_q, mode_q, dis_q, dac_q;
  logic [17:0] ton_q [CH];
  logic [17:0] cnt_q, mcnt_q, ext_per_q, hi_cnt_q, hi_q, period, thr, pwm_on, hy_ton;
  ldc_meas_e meas_q;
  logic ext, hyb, ena, ena_prev_q, fs_act, fs_hold_q, cyc_start, strap_done_q;
  logic [1:0] strap_cnt_q;
  logic [CH-1:0] ld_q, chan_on;
  logic [2:0] n_en;
  logic [17:0] step;
  logic [31:0] ref_cnt_q;
  logic upd;

  assign ext = mode_q[`LDC_MODE_EXT];
  assign hyb = mode_q[`LDC_MODE_HYB];
  assign ena = ctrl_q[`LDC_CTRL_ENA];

  // Pins cross in through two flops; only the second stage is read.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
    end else begin
      sync1_q <= {failsafe_code_in, device_en_in, failsafe_pin_in, dim_pin_in};
      sync2_q <= sync1_q;
    end
  end
  assign dim_s = sync2_q[0];
  assign fs_s = sync2_q[1];
  assign en_s = sync2_q[2];

  // The 20MHz sampling tick is an enable pulse every fifth clock.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tdiv_q <= 3'h0;
      dim_prev_q <= 1'b0;
    end else begin
      tdiv_q <= (tdiv_q == TDIV - 3'h1) ? 3'h0 : tdiv_q + 3'h1;
      if (tick) begin
        dim_prev_q <= dim_s;
      end
    end
  end
  assign tick = (tdiv_q == TDIV - 3'h1);
  assign rise = tick & dim_s & ~dim_prev_q;
  assign fall = tick & ~dim_s & dim_prev_q;

  // Straps are caught once, after the synchroniser has filled.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'b0;
      failsafe_current_out <= 2'h0;
      failsafe_avail_out <= 1'b0;
      slave_addr_out <= `LDC_ADDR_A;
    end else if (!strap_done_q) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == 2'h2) begin
        strap_done_q <= 1'b1;
        failsafe_avail_out <= (sync2_q[6:3] != 4'h0);
        failsafe_current_out <= 2'((sync2_q[6:3] - 4'h1) >> 1);
        slave_addr_out <= (sync2_q[3] || sync2_q[6:3] == 4'h0) ? `LDC_ADDR_A : `LDC_ADDR_B;
      end
    end
  end

  // Register writes; reads are returned from a flop one clock later.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_q <= `LDC_RST_CTRL;
      mode_q <= `LDC_RST_MODE;
      dis_q <= `LDC_RST_DIS;
      reg_rdata_out <= 8'h00;
    end else begin
      if (reg_req_in.wr) begin
        if (reg_req_in.addr == `LDC_OFF_CTRL) begin
          ctrl_q <= reg_req_in.wdata;
        end else if (reg_req_in.addr == `LDC_OFF_MODE) begin
          mode_q <= reg_req_in.wdata;
        end else if (reg_req_in.addr == `LDC_OFF_DIS) begin
          dis_q <= {2'b00, reg_req_in.wdata[5:0]};
        end
      end
      if (reg_req_in.rd) begin
        if (reg_req_in.addr == `LDC_OFF_CTRL) begin
          reg_rdata_out <= ctrl_q;
        end else if (reg_req_in.addr == `LDC_OFF_MODE) begin
          reg_rdata_out <= mode_q;
        end else if (reg_req_in.addr == `LDC_OFF_DIS) begin
          reg_rdata_out <= dis_q;
        end else if (reg_req_in.addr == `LDC_OFF_STAT) begin
          reg_rdata_out <= {5'h00, meas_q == LDC_M_LOCK, fs_hold_q, |ld_q};
        end else if (reg_req_in.addr == `LDC_OFF_DAC) begin
          reg_rdata_out <= dac_q;
        end else begin
          reg_rdata_out <= 8'h00;
        end
      end
    end
  end

  // Enable toggling restarts the converter after a latched fault.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ena_prev_q <= 1'b0;
    end else begin
      ena_prev_q <= ena;
    end
  end
  assign boost_restart_out = ena & ~ena_prev_q;

  // Dim frequency is learnt from the first two rising edges and then frozen.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meas_q <= LDC_M_IDLE;
      mcnt_q <= 18'h0;
      ext_per_q <= MAX_PER;
    end else if (!en_s) begin
      meas_q <= LDC_M_IDLE;
    end else begin
      case (meas_q)
        LDC_M_IDLE: begin
          mcnt_q <= 18'h0;
          if (rise) begin
            meas_q <= LDC_M_ARM;
          end
        end
        LDC_M_ARM: begin
          if (rise) begin
            ext_per_q <= (mcnt_q > MAX_PER) ? MAX_PER : mcnt_q + 18'h1;
            meas_q <= LDC_M_LOCK;
          end else if (tick && mcnt_q != 18'h3FFFF) begin
            mcnt_q <= mcnt_q + 18'h1;
          end
        end
        default: meas_q <= LDC_M_LOCK;
      endcase
    end
  end

  // High time of the dim pin, kept from the last completed pulse or the running count once it reaches the measured period.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hi_cnt_q <= 18'h0;
      hi_q <= 18'h0;
    end else if (rise) begin
      hi_cnt_q <= 18'h1;
    end else if (fall) begin
      hi_q <= hi_cnt_q;
    end else if (tick && dim_s && hi_cnt_q != 18'h3FFFF) begin
      hi_cnt_q <= hi_cnt_q + 18'h1;
      if (hi_cnt_q >= ext_per_q) begin
        hi_q <= hi_cnt_q;
      end
    end
  end

  // Period counter counts 50ns ticks and restarts at each boundary.
  assign period = ext ? ext_per_q : PER;
  assign cyc_start = ext ? rise : (tick && cnt_q >= PER - 18'h1);
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_q <= 18'h0;
    end else if (cyc_start) begin
      cnt_q <= 18'h0;
    end else if (tick && cnt_q != 18'h3FFFF) begin
      cnt_q <= cnt_q + 18'h1;
    end
  end

  // Hybrid: above the crossover only current falls, below it the current is held and chopped.
  assign hy_ton = ext ? hi_q : ton_q[0];
  assign thr = period >> (3'h4 - {1'b0, mode_q[`LDC_MODE_THR +: 2]});
  assign pwm_on = (hy_ton >= thr) ? period : 18'(hy_ton << (3'h4 - {1'b0, mode_q[`LDC_MODE_THR +: 2]}));
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hybrid_level_out <= 18'h0;
    end else begin
      hybrid_level_out <= !hyb ? period : ((hy_ton >= thr) ? hy_ton : thr);
    end
  end

  // Strings are disabled from the top, so the enabled count sets the phase step.
  assign n_en = 3'(CH) - 3'($countones(dis_q[CH-1:0]));
  always_comb begin
    case (n_en)
      3'h2: step = PER / 18'h2;
      3'h3: step = PER / 18'h3;
      3'h4: step = PER / 18'h4;
      3'h5: step = PER / 18'h5;
      3'h6: step = PER / 18'h6;
      default: step = 18'h0;
    endcase
  end

  // Per-channel pulse and low-dim logic.
  genvar c;
  generate
    for (c = 0; c < CH; c++) begin : g_ch
      logic [17:0] on_t, on_eff, offs, pc, eon;
      assign on_t = hyb ? pwm_on : ton_q[c];
      assign on_eff = (on_t != 18'h0 && on_t < MIN_ON) ? MIN_ON : on_t;
      assign offs = (ctrl_q[`LDC_CTRL_PHASE_SHIFT_ENABLE] && !ext) ? 18'(step * 18'(c)) : 18'h0;
      assign pc = (cnt_q >= offs) ? cnt_q - offs : 18'(cnt_q + PER - offs);
      assign eon = (ext && !hyb) ? hi_q : on_eff;
      always_comb begin
        if (dis_q[c]) begin
          chan_on[c] = 1'b0;
        end else if (ext && !hyb) begin
          chan_on[c] = dim_s;
        end else if (on_t == 18'h0) begin
          chan_on[c] = 1'b0;
        end else begin
          chan_on[c] = (on_t >= period) || (pc < on_eff);
        end
      end
      always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          ton_q[c] <= 18'h0;
          ld_q[c] <= 1'b0;
        end else begin
          if (reg_req_in.wr && reg_req_in.addr == `LDC_OFF_TON0 + 8'(3 * c)) begin
            ton_q[c][7:0] <= reg_req_in.wdata;
          end
          if (reg_req_in.wr && reg_req_in.addr == `LDC_OFF_TON0 + 8'(3 * c + 1)) begin
            ton_q[c][15:8] <= reg_req_in.wdata;
          end
          if (reg_req_in.wr && reg_req_in.addr == `LDC_OFF_TON0 + 8'(3 * c + 2)) begin
            ton_q[c][17:16] <= reg_req_in.wdata[1:0];
          end
          if (cyc_start) begin
            if (eon < 18'(`LDC_LD_ENTER_TICKS)) begin
              ld_q[c] <= ~dis_q[c];
            end else if (eon > 18'(`LDC_LD_EXIT_TICKS)) begin
              ld_q[c] <= 1'b0;
            end
          end
        end
      end
    end
  endgenerate

  // Fail-safe override holds until a cycle boundary after the pin drops.
  assign fs_act = fs_s & ena & failsafe_avail_out;
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fs_hold_q <= 1'b0;
      sink_on_out <= '0;
    end else begin
      if (fs_act) begin
        fs_hold_q <= 1'b1;
      end else if (cyc_start) begin
        fs_hold_q <= 1'b0;
      end
      sink_on_out <= fs_hold_q ? '1 : (ena ? chan_on : '0);
    end
  end

  // Converter mode: continuous while any string is in low-dim.
  assign low_dim_out = |ld_q;
  assign boost_on_out = ena | fs_hold_q;
  assign boost_switch_out = boost_on_out & (low_dim_out | fs_hold_q | (|sink_on_out));
  assign short_detect_en_out = ~low_dim_out;
  assign sink_monitor_en_out = ~low_dim_out;
  assign boost_monitor_en_out = 1'b1;

  // Reference counter steps on each dim edge in external mode or each period start in internal mode, or after 10ms with neither.
  assign upd = (ext ? (rise | fall) : cyc_start) || (ref_cnt_q >= REFRESH_CYCLES - 1);
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ref_cnt_q <= 32'h0;
      dac_q <= DAC_MIN;
    end else begin
      ref_cnt_q <= upd ? 32'h0 : ref_cnt_q + 32'h1;
      if (upd && headroom_low_in && dac_q < DAC_MAX) begin
        dac_q <= dac_q + 8'h01;
      end else if (upd && headroom_high_in && !headroom_low_in && dac_q > DAC_MIN) begin
        dac_q <= dac_q - 8'h01;
      end
    end
  end
  assign dac_code_out = dac_q;

  // Checks.
  logic [15:0] hw_cnt_q;
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hw_cnt_q <= 16'h0;
    end else begin
      hw_cnt_q <= sink_on_out[0] ? hw_cnt_q + 16'h1 : 16'h0;
    end
  end
  sequence s_fs_on;
    fs_act;
  endsequence
  sequence s_fs_release;
    fs_hold_q && !fs_act && !cyc_start;
  endsequence
  AST_DAC_RANGE: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    dac_q >= DAC_MIN && dac_q <= DAC_MAX) else $error("reference code out of range");
  AST_FS_ALL_ON: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    s_fs_on |-> ##2 (sink_on_out == '1 && boost_on_out)) else $error("fail-safe did not force sinks");
  AST_FS_HOLD: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    s_fs_release |=> fs_hold_q) else $error("fail-safe released before cycle start");
  AST_STRAP_STABLE: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    strap_done_q |=> $stable(slave_addr_out) && $stable(failsafe_current_out)) else $error("strap changed");
  AST_FREQ_LOCK: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (meas_q == LDC_M_LOCK && en_s) |=> $stable(ext_per_q)) else $error("dim period changed while locked");
  AST_MIN_PULSE: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    ($fell(sink_on_out[0]) && !ext && !hyb && !fs_hold_q && $stable(ton_q[0]) && ton_q[0] != 18'h0 && $past(ena, 60))
    |-> hw_cnt_q >= 16'(MIN_CLKS)) else $error("on pulse shorter than minimum");
  AST_ZERO_OFF: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (!ext && !hyb && ton_q[2] == 18'h0 && !fs_hold_q) |=> !sink_on_out[2]) else $error("zero on-time drove sink");
  AST_DIS_OFF: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (dis_q[4] && !fs_hold_q) |=> !sink_on_out[4]) else $error("disabled string driven");
  AST_LOWDIM: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (|ld_q && boost_on_out) |-> (boost_switch_out && !short_detect_en_out)) else $error("low-dim not continuous");
  AST_DAC_STEP: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    !upd |=> $stable(dac_q)) else $error("reference stepped without update");
endmodule
`default_nettype wire

// >>> ldc_cfg.svh
// Constants of the LED dimming controller: offsets, fields, reset values and timing.
`ifndef LDC_CFG_SVH
`define LDC_CFG_SVH
`define LDC_OFF_CTRL 8'h02
`define LDC_OFF_MODE 8'h03
`define LDC_OFF_DIS 8'h13
`define LDC_OFF_TON0 8'h04
`define LDC_OFF_STAT 8'h20
`define LDC_OFF_DAC 8'h21
`define LDC_CTRL_ENA 7
`define LDC_CTRL_PHASE_SHIFT_ENABLE 6
`define LDC_MODE_EXT 0
`define LDC_MODE_HYB 1
`define LDC_MODE_THR 2
`define LDC_RST_CTRL 8'h00
`define LDC_RST_MODE 8'h01
`define LDC_RST_DIS 8'h00
`define LDC_CLK_MHZ 100
`define LDC_TICK_MHZ 20
`define LDC_TICK_DIV (`LDC_CLK_MHZ / `LDC_TICK_MHZ)
`define LDC_TICK_NS 50
`define LDC_MIN_ON_NS 500
`define LDC_MIN_ON_TICKS ((`LDC_MIN_ON_NS + `LDC_TICK_NS - 1) / `LDC_TICK_NS)
`define LDC_LD_ENTER_US 50
`define LDC_LD_EXIT_US 51
`define LDC_LD_ENTER_TICKS (`LDC_LD_ENTER_US * 1000 / `LDC_TICK_NS)
`define LDC_LD_EXIT_TICKS ((`LDC_LD_EXIT_US * 1000 + `LDC_TICK_NS - 1) / `LDC_TICK_NS)
`define LDC_DIM_MIN_HZ 100
`define LDC_MAX_PER_TICKS (`LDC_TICK_MHZ * 1000000 / `LDC_DIM_MIN_HZ)
`define LDC_REFRESH_MS 10
`define LDC_REFRESH_CYCLES (`LDC_REFRESH_MS * 1000 * `LDC_CLK_MHZ)
`define LDC_DAC_STEP_UV 2500
`define LDC_REF_MIN_MV 600
`define LDC_REF_MAX_MV 1250
`define LDC_DAC_MIN (`LDC_REF_MIN_MV * 1000 / `LDC_DAC_STEP_UV)
`define LDC_DAC_MAX_RAW (`LDC_REF_MAX_MV * 1000 / `LDC_DAC_STEP_UV)
`define LDC_ADDR_A 7'h60
`define LDC_ADDR_B 7'h66
`define LDC_PWM_PERIOD_TICKS 100000
`endif

// >>> ldc_pkg.sv
// Types shared by the LED dimming controller.
package ldc_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ldc_reg_req_s;
  typedef enum logic [1:0] {
    LDC_M_IDLE = 2'b00,
    LDC_M_ARM = 2'b01,
    LDC_M_LOCK = 2'b10
  } ldc_meas_e;
endpackage

// >>> ldc_dim_source.sv
// Behavioural dim PWM source standing in for the host's dimming output.
`timescale 1ns/100ps
`default_nettype none
module ldc_dim_source (
  // Control from the bench.
  input wire logic run_in,
  input wire logic hold_high_in,
  input wire logic [7:0] high_in,
  input wire logic [7:0] low_in,
  // Dim pin.
  output logic dim_out
);
  logic base_clk;
  int cnt;
  // Own 80 ns timebase, offset so it never lines up with the block clock.
  initial begin
    base_clk = 1'b0;
    dim_out = 1'b0;
    cnt = 0;
    #3.7;
    forever #40 base_clk = ~base_clk;
  end
  // Pulse train; the bench picks a frequency far above the 100Hz floor.
  // Settings only change while stopped, so no runt pulse reaches the pin.
  always @(posedge base_clk) begin
    if (!run_in) begin
      cnt <= 0;
      dim_out <= hold_high_in;
    end else begin
      cnt <= (cnt + 1 >= int'(high_in) + int'(low_in)) ? 0 : cnt + 1;
      dim_out <= (cnt < int'(high_in));
    end
  end
endmodule
`default_nettype wire

// >>> led_dimming_control_tb.sv
// Self-checking bench for the LED dimming controller core.
`timescale 1ns/100ps
`default_nettype none
module led_dimming_control_tb;
  import ldc_pkg::*;
  localparam int PER = 1200;
  localparam int PCYC = PER * 5;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  ldc_reg_req_s req = '0;
  logic fs_pin = 1'b0, dev_en = 1'b1, hr_lo = 1'b0, hr_hi = 1'b0, run = 1'b0, hold = 1'b0;
  logic [3:0] fs_code = 4'h8;
  logic dim;
  logic [7:0] rdata, dac;
  logic [5:0] sink;
  logic [17:0] hlevel;
  logic boost_on, restart, low_dim, short_en, mon_en, bmon_en, fs_avail, bsw;
  logic [1:0] fs_cur;
  logic [6:0] saddr;
  int err_total = 0;
  int check_count = 0;
  int hi [6];

  // Short internal period keeps the run brief; expectations derive from PER.
  ldc_dimming_core #(.CH(6), .PWM_PERIOD_TICKS(PER), .REFRESH_CYCLES(500)) DUT (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .reg_req_in(req), .reg_rdata_out(rdata),
    .dim_pin_in(dim), .failsafe_pin_in(fs_pin), .device_en_in(dev_en), .failsafe_code_in(fs_code),
    .headroom_low_in(hr_lo), .headroom_high_in(hr_hi), .sink_on_out(sink), .hybrid_level_out(hlevel),
    .dac_code_out(dac), .boost_on_out(boost_on), .boost_switch_out(bsw), .boost_restart_out(restart),
    .low_dim_out(low_dim), .short_detect_en_out(short_en), .sink_monitor_en_out(mon_en),
    .boost_monitor_en_out(bmon_en), .failsafe_current_out(fs_cur), .failsafe_avail_out(fs_avail),
    .slave_addr_out(saddr));

  // Dim source with its own free timebase.
  ldc_dim_source src (.run_in(run), .hold_high_in(hold), .high_in(8'h19), .low_in(8'h4B), .dim_out(dim));

  // 100 MHz block clock.
  initial begin
    forever #5 mclk_in = ~mclk_in;
  end

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Every bench step lands 1 ns after a rising edge so the design never races it.
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: %s got %0h expected %0h", $time, msg, got, exp);
    end
  endtask

  // An idle edge first, so back-to-back writes never drop and raise the strobe in one step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    tick(1);
    req.wr = 1'b0;
  endtask

  // Read data is registered at the taking edge; one spare edge is harmless as it stands.
  task automatic rd(input logic [7:0] a);
    req.rd = 1'b1;
    req.addr = a;
    tick(1);
    req.rd = 1'b0;
    tick(1);
  endtask

  task automatic set_ton(input int c, input logic [17:0] v);
    wr(8'h04 + 8'(3 * c), v[7:0]);
    wr(8'h05 + 8'(3 * c), v[15:8]);
    wr(8'h06 + 8'(3 * c), {6'h00, v[17:16]});
  endtask

  // Counts high cycles of every sink over exactly one internal period.
  task automatic measure();
    for (int c = 0; c < 6; c++) hi[c] = 0;
    repeat (PCYC) begin
      for (int c = 0; c < 6; c++) hi[c] += (sink[c] === 1'b1) ? 1 : 0;
      tick(1);
    end
  endtask

  task automatic wait_dim(input logic v);
    for (int i = 0; i < 2000 && dim !== v; i++) tick(1);
    if (dim !== v) begin
      err_total++;
      $display("MISMATCH at %0t: dim pin never reached %0b", $time, v);
    end
  endtask

  task automatic t_reset();
    rd(8'h02);
    chk(rdata, 8'h00, "ctrl reset");
    rd(8'h03);
    chk(rdata, 8'h01, "mode reset");
    rd(8'h7F);
    chk(rdata, 8'h00, "unmapped read");
    wr(8'h13, 8'hFF);
    rd(8'h13);
    chk(rdata, 8'h3F, "disable upper bits");
    chk(dac, 8'hF0, "reference floor at reset");
    chk({fs_avail, fs_cur, saddr}, {1'b1, 2'h3, 7'h66}, "straps");
    fs_code = 4'h0;
    tick(6);
    chk({fs_avail, fs_cur, saddr}, {1'b1, 2'h3, 7'h66}, "straps kept");
    $display("Test reset done");
  endtask

  task automatic t_internal();
    wr(8'h13, 8'h30);
    set_ton(0, 18'h00003);
    set_ton(1, 18'h00028);
    set_ton(2, 18'h00000);
    set_ton(3, 18'h3FFFF);
    set_ton(4, 18'h00028);
    wr(8'h03, 8'h00);
    wr(8'h02, 8'h80);
    chk({boost_on, restart}, 2'b11, "enable starts boost");
    tick(1);
    chk(restart, 1'b0, "restart pulse length");
    tick(PCYC + 10);
    measure();
    chk(hi[0], 50, "minimum pulse");
    chk(hi[1], 200, "on-time in 50ns units");
    chk(hi[2], 0, "zero on-time");
    chk(hi[3], PCYC, "over-period on-time");
    chk(hi[4] + hi[5], 0, "disabled strings");
    chk({low_dim, short_en, mon_en, bmon_en}, 4'b1001, "low-dim effects");
    chk(bsw, 1'b1, "continuous switching in low-dim");
    $display("Test internal done");
  endtask

  task automatic t_failsafe();
    fs_pin = 1'b1;
    tick(4);
    chk({boost_on, sink}, 7'h7F, "fail-safe all on");
    fs_pin = 1'b0;
    tick(2);
    chk(sink, 6'h3F, "held until cycle start");
    tick(PCYC + 10);
    measure();
    chk(hi[2] + hi[4], 0, "registers resumed");
    $display("Test failsafe done");
  endtask

  task automatic t_phase();
    int r0, r1;
    logic [5:0] prev;
    r0 = -1;
    r1 = -1;
    wr(8'h02, 8'hC0);
    tick(PCYC + 10);
    prev = sink;
    for (int n = 0; n < 2 * PCYC && r1 < 0; n++) begin
      tick(1);
      if (sink[0] === 1'b1 && prev[0] === 1'b0 && r0 < 0) r0 = n;
      if (sink[1] === 1'b1 && prev[1] === 1'b0 && r0 >= 0) r1 = n;
      prev = sink;
    end
    chk(r1 - r0, PCYC / 4, "90 degree step for four strings");
    wr(8'h02, 8'h80);
    $display("Test phase done");
  endtask

  task automatic t_refresh();
    wr(8'h03, 8'h01);
    hold = 1'b1;
    hr_lo = 1'b1;
    tick(500 * 20);
    chk(dac, 8'hFF, "reference ceiling via refresh");
    rd(8'h21);
    chk(rdata, 8'hFF, "reference readback");
    $display("Test refresh done");
  endtask

  task automatic t_external();
    hr_lo = 1'b0;
    hr_hi = 1'b1;
    hold = 1'b0;
    run = 1'b1;
    wait_dim(1'b1);
    tick(20);
    chk({sink[0], sink[2]}, 2'b11, "sinks follow dim high");
    wait_dim(1'b0);
    tick(20);
    chk(sink[0], 1'b0, "sinks follow dim low");
    tick(10000);
    chk(dac, 8'hF0, "reference floor via edges");
    rd(8'h20);
    chk(rdata[2], 1'b1, "frequency locked");
    run = 1'b0;
    dev_en = 1'b0;
    tick(5);
    rd(8'h20);
    chk(rdata[2], 1'b0, "re-armed by enable low");
    dev_en = 1'b1;
    hr_hi = 1'b0;
    $display("Test external done");
  endtask

  task automatic t_hybrid();
    wr(8'h03, 8'h02);
    for (int c = 0; c < 6; c++) set_ton(c, 18'd600);
    tick(PCYC + 10);
    measure();
    chk(hi[0], PCYC, "current reduced, not chopped");
    chk(hlevel, 18'd600, "level from on-time");
    chk({low_dim, short_en}, 2'b01, "normal mode above exit level");
    // A nonzero step below the crossover: current is held there and the rest is chopped.
    for (int c = 0; c < 6; c++) set_ton(c, 18'd30);
    tick(PCYC + 10);
    measure();
    chk(hi[0], PCYC * 30 / (PER / 16), "chopped below crossover");
    chk(hlevel, PER / 16, "level held at crossover");
    chk({low_dim, short_en}, 2'b10, "low-dim below entry level");
    $display("Test hybrid done");
  endtask

  // Main sequence.
  initial begin
    repeat (5) @(posedge mclk_in);
    #1 resetn_in = 1'b1;
    tick(4);
    t_reset();
    t_internal();
    t_failsafe();
    t_phase();
    t_refresh();
    t_external();
    t_hybrid();
    end_of_test();
  end

  // Watchdog sized above the expected run of about 82k cycles.
  initial begin
    #950000;
    err_total++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule
`default_nettype wire
